// ==== core/cafbe_consts.vh ====
// Constants for the arithmetic, flag and branch evaluation block
`ifndef CAFBE_CONSTS_VH
`define CAFBE_CONSTS_VH

// Register byte offsets on the APB bus
`define CAFBE_OFS_CMD      8'h00
`define CAFBE_OFS_OPERAND  8'h04
`define CAFBE_OFS_ACC_ONE  8'h08
`define CAFBE_OFS_ACC_TWO  8'h0C
`define CAFBE_OFS_DOUBLE   8'h10
`define CAFBE_OFS_INDEX_X  8'h14
`define CAFBE_OFS_PC       8'h18
`define CAFBE_OFS_CCR      8'h1C
`define CAFBE_OFS_STATUS   8'h20

// Command word fields
`define CAFBE_CMD_OP_MSB   4
`define CAFBE_CMD_OP_LSB   0
`define CAFBE_CMD_LONG_BIT 8

// Operation codes
`define CAFBE_OP_NOP       5'h00
`define CAFBE_OP_ABX       5'h01
`define CAFBE_OP_ADD_CARRY_ACC_ONE      5'h02
`define CAFBE_OP_ADD_CARRY_ACC_TWO      5'h03
`define CAFBE_OP_ADD_ACC_ONE      5'h04
`define CAFBE_OP_ADD_ACC_TWO      5'h05
`define CAFBE_OP_ADD_DOUBLE_ACC      5'h06
`define CAFBE_OP_AND_ACC_ONE      5'h07
`define CAFBE_OP_AND_ACC_TWO      5'h08
`define CAFBE_OP_AND_FLAGS_IMMEDIATE     5'h09
`define CAFBE_OP_ASLA      5'h0A
`define CAFBE_OP_ASLB      5'h0B
`define CAFBE_OP_ASRA      5'h0C
`define CAFBE_OP_ASRB      5'h0D
`define CAFBE_OP_BCC       5'h0E
`define CAFBE_OP_BCS       5'h0F
`define CAFBE_OP_BEQ       5'h10
`define CAFBE_OP_BGE       5'h11
`define CAFBE_OP_BGT       5'h12
`define CAFBE_OP_ASLM      5'h13
`define CAFBE_OP_ASRM      5'h14

// Condition code bit positions
`define CAFBE_CC_E         7
`define CAFBE_CC_F         6
`define CAFBE_CC_H         5
`define CAFBE_CC_I         4
`define CAFBE_CC_N         3
`define CAFBE_CC_Z         2
`define CAFBE_CC_V         1
`define CAFBE_CC_C         0

// Reset values
`define CAFBE_CCR_RESET    8'h50
`define CAFBE_BYTE_RESET   8'h00
`define CAFBE_WORD_RESET   16'h0000

// Status register fields
`define CAFBE_ST_TAKEN     0
`define CAFBE_ST_ILLEGAL   1
`define CAFBE_ST_OP_LSB    8

// Byte unit function select
`define CAFBE_ALU_ADD      2'h0
`define CAFBE_ALU_ADC      2'h1
`define CAFBE_ALU_ASL      2'h2
`define CAFBE_ALU_ASR      2'h3

`endif

// ==== core/cafbe_alu8.v ====
// Byte add and arithmetic shift unit with flag outputs
`timescale 1ns/10ps
`include "cafbe_consts.vh"

module cafbe_alu8 (
  input  wire [1:0] func,
  input  wire [7:0] opa,
  input  wire [7:0] opm,
  input  wire       cin,
  output reg  [7:0] res,
  output reg        half,
  output reg        neg,
  output reg        zero,
  output reg        ovf,
  output reg        carry
);

  reg [8:0] sum;

  // Result and flags for the selected byte function
  always @* begin
    sum   = 9'h000;
    res   = 8'h00;
    half  = 1'b0;
    ovf   = 1'b0;
    carry = 1'b0;
    case (func)
      `CAFBE_ALU_ADD, `CAFBE_ALU_ADC: begin
        sum = {1'b0, opa} + {1'b0, opm}
              + {8'h00, (func == `CAFBE_ALU_ADC) & cin};
        res   = sum[7:0];
        half  = opa[4] ^ opm[4] ^ sum[4];
        ovf   = (opa[7] == opm[7]) & (sum[7] != opa[7]);
        carry = sum[8];
      end
      `CAFBE_ALU_ASL: begin
        res   = {opa[6:0], 1'b0};
        ovf   = opa[7] ^ opa[6];
        carry = opa[7];
      end
      `CAFBE_ALU_ASR: begin
        res   = {opa[7], opa[7:1]};
        carry = opa[0];
      end
      default: begin
        res = 8'h00;
      end
    endcase
    neg  = res[7];
    zero = (res == 8'h00);
  end

endmodule

// ==== core/cafbe_core.v ====
// Execution unit for adds, ANDs, shifts and conditional branches
//
// The APB slave port and the placing of the registers were decided locally.
`timescale 1ns/10ps
`include "cafbe_consts.vh"

// Overview of operation
// - Index X gains zero-extended accumulator two
// - Add with carry: accumulator plus byte plus carry
// - Plain byte add updates H N Z V C
// - Byte adds: nibble half-carry, sign, zero, carries
// - Double add of big-endian word, H kept
// - Accumulator AND sets N Z, clears V
// - Condition codes ANDed with immediate byte
// - Left shift inserts zero, N Z updated
// - Left shift: C old bit7, V b7^b6
// - Right shift keeps bit7, C old bit0
// - Carry clear branch adds offset, flags kept
// - Carry set branch adds offset, flags kept
// - Equal branch taken when zero is set
// - Greater-or-equal branch when N equals V
// - Greater branch when Z clear, N equals V
module cafbe_core #(
  parameter AW = 8
) (
  input  wire          CLK,
  input  wire          RST,
  input  wire          PSEL,
  input  wire          PENABLE,
  input  wire          PWRITE,
  input  wire [AW-1:0] PADDR,
  input  wire [31:0]   PWDATA,
  output reg  [31:0]   PRDATA,
  output reg           PREADY,
  output reg           PSLVERR
);

  // Architectural state
  reg  [7:0]  accumulator_one;
  reg  [7:0]  accumulator_two;
  reg  [15:0] index_register_x;
  reg  [15:0] prog_counter;
  reg  [7:0]  condition_code_register;
  reg  [15:0] operand;
  reg  [4:0]  last_op;
  reg         last_long;
  reg         last_taken;
  reg         last_illegal;

  // Next values of the execution path
  reg  [7:0]  next_acc_one;
  reg  [7:0]  next_acc_two;
  reg  [15:0] next_index_x;
  reg  [15:0] next_pc;
  reg  [7:0]  next_ccr;
  reg  [15:0] next_operand;
  reg         next_taken;
  reg         next_illegal;

  // Byte unit connections
  reg  [1:0]  alu_func;
  reg  [7:0]  alu_opa;
  wire [7:0]  alu_res;
  wire        alu_half;
  wire        alu_neg;
  wire        alu_zero;
  wire        alu_ovf;
  wire        alu_carry;

  // Double add helpers
  wire [15:0] double_acc;
  wire [16:0] double_sum;
  wire        double_ovf;

  // Bus decode
  wire [4:0]  cmd_op;
  wire        cmd_long;
  wire        bus_setup;
  wire        bus_write;
  reg  [31:0] next_rdata;
  reg         next_err;

  // Branch condition from an opcode and the current flags
  function branch_cond;
    input [4:0] op;
    input [7:0] cc;
    begin
      case (op)
        `CAFBE_OP_BCC: branch_cond = ~cc[`CAFBE_CC_C];
        `CAFBE_OP_BCS: branch_cond = cc[`CAFBE_CC_C];
        `CAFBE_OP_BEQ: branch_cond = cc[`CAFBE_CC_Z];
        `CAFBE_OP_BGE:
          branch_cond = ~(cc[`CAFBE_CC_N] ^ cc[`CAFBE_CC_V]);
        `CAFBE_OP_BGT:
          branch_cond = ~cc[`CAFBE_CC_Z]
                        & ~(cc[`CAFBE_CC_N] ^ cc[`CAFBE_CC_V]);
        default: branch_cond = 1'b0;
      endcase
    end
  endfunction

  // True for the relative branch opcodes
  function is_branch;
    input [4:0] op;
    begin
      is_branch = (op >= `CAFBE_OP_BCC) && (op <= `CAFBE_OP_BGT);
    end
  endfunction

  // Sign-extended branch offset, short or long form
  function [15:0] branch_offset;
    input [15:0] opnd;
    input        long_form;
    begin
      if (long_form) begin
        branch_offset = opnd;
      end else begin
        branch_offset = {{8{opnd[7]}}, opnd[7:0]};
      end
    end
  endfunction

  // Match of a bus address against a register offset
  function addr_is;
    input [AW-1:0] addr;
    input [7:0]    ofs;
    begin
      addr_is = (addr == ofs[AW-1:0]);
    end
  endfunction

  assign cmd_op    = PWDATA[`CAFBE_CMD_OP_MSB:`CAFBE_CMD_OP_LSB];
  assign cmd_long  = PWDATA[`CAFBE_CMD_LONG_BIT];
  assign bus_setup = PSEL & ~PENABLE;
  assign bus_write = PSEL & PENABLE & PREADY & PWRITE;

  // Double accumulator view and its 17-bit sum
  assign double_acc = {accumulator_one, accumulator_two};
  assign double_sum = {1'b0, double_acc} + {1'b0, operand};
  assign double_ovf = (double_acc[15] == operand[15])
                      & (double_sum[15] != double_acc[15]);

  // Byte unit function and operand selection
  always @* begin
    alu_func = `CAFBE_ALU_ADD;
    alu_opa  = accumulator_one;
    case (cmd_op)
      `CAFBE_OP_ADD_CARRY_ACC_ONE: alu_func = `CAFBE_ALU_ADC;
      `CAFBE_OP_ADD_CARRY_ACC_TWO: begin
        alu_func = `CAFBE_ALU_ADC;
        alu_opa  = accumulator_two;
      end
      `CAFBE_OP_ADD_ACC_TWO: alu_opa = accumulator_two;
      `CAFBE_OP_ASLA: alu_func = `CAFBE_ALU_ASL;
      `CAFBE_OP_ASLB: begin
        alu_func = `CAFBE_ALU_ASL;
        alu_opa  = accumulator_two;
      end
      `CAFBE_OP_ASRA: alu_func = `CAFBE_ALU_ASR;
      `CAFBE_OP_ASRB: begin
        alu_func = `CAFBE_ALU_ASR;
        alu_opa  = accumulator_two;
      end
      `CAFBE_OP_ASLM: begin
        alu_func = `CAFBE_ALU_ASL;
        alu_opa  = operand[7:0];
      end
      `CAFBE_OP_ASRM: begin
        alu_func = `CAFBE_ALU_ASR;
        alu_opa  = operand[7:0];
      end
      default: alu_func = `CAFBE_ALU_ADD;
    endcase
  end

  cafbe_alu8 u_alu8 (
    .func  (alu_func),
    .opa   (alu_opa),
    .opm   (operand[7:0]),
    .cin   (condition_code_register[`CAFBE_CC_C]),
    .res   (alu_res),
    .half  (alu_half),
    .neg   (alu_neg),
    .zero  (alu_zero),
    .ovf   (alu_ovf),
    .carry (alu_carry)
  );

  // Effect of the command written in this cycle
  always @* begin
    next_acc_one = accumulator_one;
    next_acc_two = accumulator_two;
    next_index_x = index_register_x;
    next_pc      = prog_counter;
    next_ccr     = condition_code_register;
    next_operand = operand;
    next_taken   = 1'b0;
    next_illegal = 1'b0;
    case (cmd_op)
      `CAFBE_OP_NOP: begin
        next_taken = 1'b0;
      end
      `CAFBE_OP_ABX: begin
        next_index_x = index_register_x
                       + {8'h00, accumulator_two};
      end
      `CAFBE_OP_ADD_CARRY_ACC_ONE, `CAFBE_OP_ADD_ACC_ONE: begin
        next_acc_one = alu_res;
        next_ccr[`CAFBE_CC_H] = alu_half;
        next_ccr[`CAFBE_CC_N] = alu_neg;
        next_ccr[`CAFBE_CC_Z] = alu_zero;
        next_ccr[`CAFBE_CC_V] = alu_ovf;
        next_ccr[`CAFBE_CC_C] = alu_carry;
      end
      `CAFBE_OP_ADD_CARRY_ACC_TWO, `CAFBE_OP_ADD_ACC_TWO: begin
        next_acc_two = alu_res;
        next_ccr[`CAFBE_CC_H] = alu_half;
        next_ccr[`CAFBE_CC_N] = alu_neg;
        next_ccr[`CAFBE_CC_Z] = alu_zero;
        next_ccr[`CAFBE_CC_V] = alu_ovf;
        next_ccr[`CAFBE_CC_C] = alu_carry;
      end
      `CAFBE_OP_ADD_DOUBLE_ACC: begin
        next_acc_one = double_sum[15:8];
        next_acc_two = double_sum[7:0];
        next_ccr[`CAFBE_CC_N] = double_sum[15];
        next_ccr[`CAFBE_CC_Z] = (double_sum[15:0] == 16'h0000);
        next_ccr[`CAFBE_CC_V] = double_ovf;
        next_ccr[`CAFBE_CC_C] = double_sum[16];
      end
      `CAFBE_OP_AND_ACC_ONE, `CAFBE_OP_AND_ACC_TWO: begin
        if (cmd_op == `CAFBE_OP_AND_ACC_ONE) begin
          next_acc_one = accumulator_one & operand[7:0];
        end else begin
          next_acc_two = accumulator_two & operand[7:0];
        end
        next_ccr[`CAFBE_CC_N] = (cmd_op == `CAFBE_OP_AND_ACC_ONE) ?
          next_acc_one[7] : next_acc_two[7];
        next_ccr[`CAFBE_CC_Z] = (cmd_op == `CAFBE_OP_AND_ACC_ONE) ?
          (next_acc_one == 8'h00) : (next_acc_two == 8'h00);
        next_ccr[`CAFBE_CC_V] = 1'b0;
      end
      `CAFBE_OP_AND_FLAGS_IMMEDIATE: begin
        next_ccr = condition_code_register & operand[7:0];
      end
      `CAFBE_OP_ASLA, `CAFBE_OP_ASLB, `CAFBE_OP_ASLM,
      `CAFBE_OP_ASRA, `CAFBE_OP_ASRB, `CAFBE_OP_ASRM: begin
        if (cmd_op == `CAFBE_OP_ASLA || cmd_op == `CAFBE_OP_ASRA) begin
          next_acc_one = alu_res;
        end else if (cmd_op == `CAFBE_OP_ASLB
                     || cmd_op == `CAFBE_OP_ASRB) begin
          next_acc_two = alu_res;
        end else begin
          next_operand = {8'h00, alu_res};
        end
        // Half-carry is left as it was, being undefined for shifts
        next_ccr[`CAFBE_CC_N] = alu_neg;
        next_ccr[`CAFBE_CC_Z] = alu_zero;
        next_ccr[`CAFBE_CC_C] = alu_carry;
        if (alu_func == `CAFBE_ALU_ASL) begin
          next_ccr[`CAFBE_CC_V] = alu_ovf;
        end
      end
      default: begin
        if (is_branch(cmd_op)) begin
          // Flags stay as they were for every branch
          next_taken = branch_cond(cmd_op, condition_code_register);
          if (next_taken) begin
            next_pc = prog_counter
                      + branch_offset(operand, cmd_long);
          end
        end else begin
          next_illegal = 1'b1;
        end
      end
    endcase
  end

  // Read data and error answer for the addressed register
  always @* begin
    next_rdata = 32'h0000_0000;
    next_err   = 1'b0;
    if (PADDR[1:0] != 2'b00) begin
      next_err = 1'b1;
    end else if (addr_is(PADDR, `CAFBE_OFS_CMD)) begin
      next_rdata[`CAFBE_CMD_OP_MSB:`CAFBE_CMD_OP_LSB] = last_op;
      next_rdata[`CAFBE_CMD_LONG_BIT] = last_long;
    end else if (addr_is(PADDR, `CAFBE_OFS_OPERAND)) begin
      next_rdata[15:0] = operand;
    end else if (addr_is(PADDR, `CAFBE_OFS_ACC_ONE)) begin
      next_rdata[7:0] = accumulator_one;
    end else if (addr_is(PADDR, `CAFBE_OFS_ACC_TWO)) begin
      next_rdata[7:0] = accumulator_two;
    end else if (addr_is(PADDR, `CAFBE_OFS_DOUBLE)) begin
      next_rdata[15:0] = double_acc;
    end else if (addr_is(PADDR, `CAFBE_OFS_INDEX_X)) begin
      next_rdata[15:0] = index_register_x;
    end else if (addr_is(PADDR, `CAFBE_OFS_PC)) begin
      next_rdata[15:0] = prog_counter;
    end else if (addr_is(PADDR, `CAFBE_OFS_CCR)) begin
      next_rdata[7:0] = condition_code_register;
    end else if (addr_is(PADDR, `CAFBE_OFS_STATUS)) begin
      next_rdata[`CAFBE_ST_TAKEN]   = last_taken;
      next_rdata[`CAFBE_ST_ILLEGAL] = last_illegal;
      next_rdata[`CAFBE_ST_OP_LSB+4:`CAFBE_ST_OP_LSB] = last_op;
    end else begin
      next_err = 1'b1;
    end
  end

  // APB answer: one wait-free access phase after each setup cycle
  always @(posedge CLK) begin
    if (RST) begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h0000_0000;
    end else begin
      PREADY  <= bus_setup;
      PSLVERR <= bus_setup & next_err;
      if (bus_setup && !PWRITE) begin
        PRDATA <= next_rdata;
      end
    end
  end

  // Register writes and command execution
  always @(posedge CLK) begin
    if (RST) begin
      accumulator_one         <= `CAFBE_BYTE_RESET;
      accumulator_two         <= `CAFBE_BYTE_RESET;
      index_register_x        <= `CAFBE_WORD_RESET;
      prog_counter            <= `CAFBE_WORD_RESET;
      condition_code_register <= `CAFBE_CCR_RESET;
      operand                 <= `CAFBE_WORD_RESET;
      last_op                 <= `CAFBE_OP_NOP;
      last_long               <= 1'b0;
      last_taken              <= 1'b0;
      last_illegal            <= 1'b0;
    end else if (bus_write && PADDR[1:0] == 2'b00) begin
      if (addr_is(PADDR, `CAFBE_OFS_CMD)) begin
        accumulator_one         <= next_acc_one;
        accumulator_two         <= next_acc_two;
        index_register_x        <= next_index_x;
        prog_counter            <= next_pc;
        condition_code_register <= next_ccr;
        operand                 <= next_operand;
        last_op                 <= cmd_op;
        last_long               <= cmd_long;
        last_taken              <= next_taken;
        last_illegal            <= next_illegal;
      end else if (addr_is(PADDR, `CAFBE_OFS_OPERAND)) begin
        operand <= PWDATA[15:0];
      end else if (addr_is(PADDR, `CAFBE_OFS_ACC_ONE)) begin
        accumulator_one <= PWDATA[7:0];
      end else if (addr_is(PADDR, `CAFBE_OFS_ACC_TWO)) begin
        accumulator_two <= PWDATA[7:0];
      end else if (addr_is(PADDR, `CAFBE_OFS_DOUBLE)) begin
        accumulator_one <= PWDATA[15:8];
        accumulator_two <= PWDATA[7:0];
      end else if (addr_is(PADDR, `CAFBE_OFS_INDEX_X)) begin
        index_register_x <= PWDATA[15:0];
      end else if (addr_is(PADDR, `CAFBE_OFS_PC)) begin
        prog_counter <= PWDATA[15:0];
      end else if (addr_is(PADDR, `CAFBE_OFS_CCR)) begin
        condition_code_register <= PWDATA[7:0];
      end
    end
  end

endmodule

// ==== tb/cafbe_core_asserts.sv ====
// Checker for the bus timing of the arithmetic, flag and branch block
`timescale 1ns/10ps

module cafbe_core_asserts #(
  parameter AW = 8
) (
  input wire          CLK,
  input wire          RST,
  input wire          PSEL,
  input wire          PENABLE,
  input wire          PWRITE,
  input wire [AW-1:0] PADDR,
  input wire [31:0]   PWDATA,
  input wire [31:0]   PRDATA,
  input wire          PREADY,
  input wire          PSLVERR
);
  default clocking dc @(posedge CLK);
  endclocking
  default disable iff (RST);

  // Setup cycles: any, and those to a refused address
  sequence s_setup;
    PSEL && !PENABLE;
  endsequence
  sequence s_bad;
    s_setup ##0 (PADDR[1:0] != 2'b00 || PADDR > 8'h20);
  endsequence
  sequence s_good;
    s_setup ##0 (PADDR[1:0] == 2'b00 && PADDR <= 8'h20);
  endsequence

  // Zero wait state answer, exactly one cycle wide
  a_ready_after_setup: assert property (s_setup |=> PREADY)
    else $error("ready missing after setup");
  a_ready_has_cause: assert property (PREADY |-> $past(PSEL) && !$past(PENABLE))
    else $error("ready without preceding setup");
  a_ready_single: assert property (PREADY |=> !PREADY)
    else $error("ready held longer than one cycle");

  // Error flag follows the address decode
  a_err_with_ready: assert property (PSLVERR |-> PREADY)
    else $error("error flag without ready");
  a_bad_addr_err: assert property (s_bad |=> PSLVERR)
    else $error("refused address not flagged");
  a_good_addr_ok: assert property (s_good |=> !PSLVERR)
    else $error("mapped address flagged as error");

  // Read data changes only on a read setup, refused reads give zero
  a_rdata_hold: assert property (!(PSEL && !PENABLE && !PWRITE) |=> $stable(PRDATA))
    else $error("read data changed outside a read");
  a_bad_read_zero: assert property (s_bad ##0 !PWRITE |=> PRDATA == 32'h0000_0000)
    else $error("refused read returned nonzero data");
endmodule

bind cafbe_core cafbe_core_asserts #(.AW(AW)) u_asserts (
  .CLK(CLK),
  .RST(RST),
  .PSEL(PSEL),
  .PENABLE(PENABLE),
  .PWRITE(PWRITE),
  .PADDR(PADDR),
  .PWDATA(PWDATA),
  .PRDATA(PRDATA),
  .PREADY(PREADY),
  .PSLVERR(PSLVERR)
);

// ==== tb/cafbe_core_test.sv ====
// Self-checking bench for the arithmetic, flag and branch block
`timescale 1ns/10ps
`include "cafbe_consts.vh"

`define CHK(nm, ex, got) \
  begin \
    cmp_count = cmp_count + 1; \
    if ((got) !== (ex)) begin \
      miscompares = miscompares + 1; \
      $display("unexpected %0s exp %h got %h", nm, ex, got); \
    end \
  end

module cafbe_core_test;
  reg         clk;
  reg         rst;
  reg         psel;
  reg         penable;
  reg         pwrite;
  reg  [7:0]  paddr;
  reg  [31:0] pwdata;
  wire [31:0] prdata;
  wire        pready;
  wire        pslverr;
  integer     miscompares;
  integer     cmp_count;
  integer     cycles = 0;
  integer     i;
  integer     j;
  reg  [31:0] q;
  reg  [7:0]  a;
  reg  [7:0]  m;
  reg  [7:0]  cc;
  reg  [4:0]  op;
  reg  [15:0] ex;
  reg  [15:0] pc_exp;
  reg         tk;

  cafbe_core #(.AW(8)) dut (
    .CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr)
  );

  // Clock at 100 MHz
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Hang guard
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 30000) begin
      miscompares = miscompares + 1;
      report_and_stop;
    end
  end

  // One bus transfer, then one idle cycle; q holds read data
  task xfer(input [7:0] ad, input w, input [31:0] d, input ee);
    integer n;
    begin
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      @(posedge clk);
      while (pready !== 1'b1 && n < 16) begin
        n = n + 1;
        @(posedge clk);
      end
      `CHK("ready", 1'b1, pready)
      `CHK("error", ee, pslverr)
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
    end
  endtask

  task wr(input [7:0] ad, input [31:0] d);
    xfer(ad, 1'b1, d, 1'b0);
  endtask

  task rd(input [8*6-1:0] nm, input [7:0] ad, input [31:0] e);
    begin
      xfer(ad, 1'b0, 32'h0000_0000, 1'b0);
      `CHK(nm, e, q)
    end
  endtask

  task done(input [8*8-1:0] nm);
    $display("test %0s done, miscompares %0d", nm, miscompares);
  endtask

  // Load target, flags and operand, run a command, check result and flags
  task op_case(input [4:0] o, input [7:0] tg, input [15:0] ac,
               input [15:0] od, input [7:0] ci, input [15:0] r,
               input [7:0] cx, input [7:0] mk);
    begin
      wr(tg, {16'h0000, ac});
      wr(`CAFBE_OFS_CCR, {24'h00_0000, ci});
      wr(`CAFBE_OFS_OPERAND, {16'h0000, od});
      wr(`CAFBE_OFS_CMD, {27'h000_0000, o});
      rd("result", tg, {16'h0000, r});
      xfer(`CAFBE_OFS_CCR, 1'b0, 32'h0000_0000, 1'b0);
      `CHK("flags", cx & mk, q[7:0] & mk)
    end
  endtask

  // Expected result and flags of a byte add
  function [15:0] add_exp(input [7:0] x, input [7:0] y, input [7:0] ci,
                          input c);
    reg [8:0] s;
    reg       h;
    begin
      s = x + y + c;
      h = ({1'b0, x[3:0]} + y[3:0] + c) > 5'h0F;
      add_exp = {s[7:0], ci[7:6], h, ci[4], s[7], s[7:0] == 8'h00,
                 x[7] == y[7] && s[7] != x[7], s[8]};
    end
  endfunction

  task report_and_stop;
    begin
      $display("comparisons %0d miscompares %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
        $display("[ PASS ]");
      end else begin
        $display("[ FAIL ]");
      end
      $finish;
    end
  endtask

  // Main sequence
  initial begin
    miscompares = 0;
    cmp_count = 0;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd("ccr", `CAFBE_OFS_CCR, 32'h0000_0050);
    rd("double", `CAFBE_OFS_DOUBLE, 32'h0000_0000);
    rd("pc", `CAFBE_OFS_PC, 32'h0000_0000);
    rd("status", `CAFBE_OFS_STATUS, 32'h0000_0000);
    done("reset");
    wr(`CAFBE_OFS_ACC_TWO, 32'h0000_00FF);
    op_case(5'h01, `CAFBE_OFS_INDEX_X, 16'h12F0, 16'h0000, 8'h5F,
            16'h13EF, 8'h5F, 8'hFF);
    for (i = 0; i < 16; i = i + 1) begin
      a = 32'h087F_FF80 >> (8 * (i % 4));
      m = 32'h0801_0180 >> (8 * (i % 4));
      op = `CAFBE_OP_ADD_CARRY_ACC_ONE + i / 4;
      cc = {4'hA, 3'b000, i[2] ^ i[0]};
      ex = add_exp(a, m, cc, cc[0] && op < `CAFBE_OP_ADD_ACC_ONE);
      op_case(op, op[0] ? `CAFBE_OFS_ACC_TWO : `CAFBE_OFS_ACC_ONE,
              {8'h00, a}, {8'h00, m}, cc, {8'h00, ex[15:8]}, ex[7:0],
              8'hFF);
    end
    done("add");
    op_case(5'h06, `CAFBE_OFS_DOUBLE, 16'h7FF0, 16'h0010, 8'h20,
            16'h8000, 8'h2A, 8'hFF);
    rd("acc1", `CAFBE_OFS_ACC_ONE, 32'h0000_0080);
    op_case(5'h06, `CAFBE_OFS_DOUBLE, 16'hFFFF, 16'h0001, 8'h0A,
            16'h0000, 8'h05, 8'hFF);
    op_case(5'h07, `CAFBE_OFS_ACC_ONE, 16'h00F0, 16'h008F, 8'h23,
            16'h0080, 8'h29, 8'hFF);
    op_case(5'h08, `CAFBE_OFS_ACC_TWO, 16'h000F, 16'h00F0, 8'h2B,
            16'h0000, 8'h25, 8'hFF);
    op_case(5'h09, `CAFBE_OFS_CCR, 16'h00FF, 16'h00A5, 8'hFF,
            16'h00A5, 8'hA5, 8'hFF);
    done("logic");
    // Shifts; half-carry is masked off as it is undefined
    op_case(5'h0A, `CAFBE_OFS_ACC_ONE, 16'h0040, 16'h0000, 8'h00,
            16'h0080, 8'h0A, 8'hDF);
    op_case(5'h0B, `CAFBE_OFS_ACC_TWO, 16'h0080, 16'h0000, 8'h08,
            16'h0000, 8'h07, 8'hDF);
    op_case(5'h13, `CAFBE_OFS_OPERAND, 16'h00C0, 16'h00C0, 8'h00,
            16'h0080, 8'h09, 8'hDF);
    op_case(5'h0C, `CAFBE_OFS_ACC_ONE, 16'h0081, 16'h0000, 8'h02,
            16'h00C0, 8'h0B, 8'hDF);
    op_case(5'h0D, `CAFBE_OFS_ACC_TWO, 16'h0001, 16'h0000, 8'h00,
            16'h0000, 8'h05, 8'hDF);
    op_case(5'h14, `CAFBE_OFS_OPERAND, 16'h0002, 16'h0002, 8'h03,
            16'h0001, 8'h02, 8'hDF);
    done("shift");
    // Every branch over every N Z V C pattern, short and long form
    for (j = 0; j < 2; j = j + 1) begin
      for (i = 0; i < 80; i = i + 1) begin
        cc = {4'h0, i[3:0]};
        op = `CAFBE_OP_BCC + i / 16;
        case (i / 16)
          0: tk = !cc[0];
          1: tk = cc[0];
          2: tk = cc[2];
          3: tk = cc[3] == cc[1];
          default: tk = !cc[2] && cc[3] == cc[1];
        endcase
        pc_exp = 16'h1000 + (!tk ? 16'h0000 : j ? 16'h7FF0 : 16'hFFF0);
        wr(`CAFBE_OFS_PC, 32'h0000_1000);
        wr(`CAFBE_OFS_CCR, {24'h00_0000, cc});
        wr(`CAFBE_OFS_OPERAND, 32'h0000_7FF0);
        wr(`CAFBE_OFS_CMD, {23'h00_0000, j[0], 3'b000, op});
        rd("pc", `CAFBE_OFS_PC, {16'h0000, pc_exp});
        rd("flags", `CAFBE_OFS_CCR, {24'h00_0000, cc});
        xfer(`CAFBE_OFS_STATUS, 1'b0, 32'h0000_0000, 1'b0);
        `CHK("taken", tk, q[0])
      end
    end
    done("branch");
    // Illegal command, read-only status, refused addresses
    wr(`CAFBE_OFS_ACC_ONE, 32'h0000_0033);
    wr(`CAFBE_OFS_CMD, 32'h0000_0015);
    wr(`CAFBE_OFS_STATUS, 32'hFFFF_FFFF);
    xfer(`CAFBE_OFS_STATUS, 1'b0, 32'h0000_0000, 1'b0);
    `CHK("status", 32'h0000_1502, q & 32'hFFFF_FFFE)
    xfer(8'h24, 1'b0, 32'h0000_0000, 1'b1);
    `CHK("unmapped", 32'h0000_0000, q)
    xfer(8'h09, 1'b1, 32'h0000_00FF, 1'b1);
    rd("acc1", `CAFBE_OFS_ACC_ONE, 32'h0000_0033);
    done("refuse");
    report_and_stop;
  end
endmodule
